// file: fan_ctl_pkg.sv
// shared constants, register map and carrier types for the thermal fan controller
package fan_ctl_pkg;

    localparam int CLK_HZ = 50_000_000;
    localparam int MS_PER_S = 1000;
    localparam int MS_CYCLES = CLK_HZ / MS_PER_S;
    localparam int CONV_TIME_MS = 120;
    localparam int CONV_CYCLES = MS_CYCLES * CONV_TIME_MS;
    localparam int SPINUP_TIME_MS = 2000;

    localparam logic [7:0] DUTY_FULL = 8'hF0;
    localparam logic [7:0] PEAK_DROP_C = 8'h05;
    localparam logic [7:0] HYST_LO_C = 8'h05;
    localparam logic [7:0] HYST_HI_C = 8'h0A;

    localparam logic [7:0] ADDR_TEMP1 = 8'h00;
    localparam logic [7:0] ADDR_TEMP2 = 8'h01;
    localparam logic [7:0] ADDR_CFG = 8'h02;
    localparam logic [7:0] ADDR_OT_LIM1 = 8'h03;
    localparam logic [7:0] ADDR_OT_LIM2 = 8'h04;
    localparam logic [7:0] ADDR_OT_STATUS = 8'h05;
    localparam logic [7:0] ADDR_OT_MASK = 8'h06;
    localparam logic [7:0] ADDR_START_DUTY1 = 8'h07;
    localparam logic [7:0] ADDR_START_DUTY2 = 8'h08;
    localparam logic [7:0] ADDR_MAX_DUTY1 = 8'h09;
    localparam logic [7:0] ADDR_MAX_DUTY2 = 8'h0A;
    localparam logic [7:0] ADDR_TARGET1 = 8'h0B;
    localparam logic [7:0] ADDR_TARGET2 = 8'h0C;
    localparam logic [7:0] ADDR_START_TEMP1 = 8'h0D;
    localparam logic [7:0] ADDR_START_TEMP2 = 8'h0E;
    localparam logic [7:0] ADDR_DUTY_STEP = 8'h0F;
    localparam logic [7:0] ADDR_RATE = 8'h10;
    localparam logic [7:0] ADDR_FAN_CFG = 8'h11;
    localparam logic [7:0] ADDR_FREQ = 8'h12;
    localparam logic [7:0] ADDR_DUTY1 = 8'h13;
    localparam logic [7:0] ADDR_DUTY2 = 8'h14;
    localparam logic [7:0] ADDR_TEMP1_LO = 8'h15;
    localparam logic [7:0] ADDR_TEMP2_LO = 8'h16;
    localparam logic [7:0] ADDR_OFFSET = 8'h17;

    localparam logic [7:0] CFG_RST = 8'h18;
    localparam logic [7:0] OT_LIM1_RST = 8'h6E;
    localparam logic [7:0] OT_LIM2_RST = 8'h50;
    localparam logic [7:0] ZERO_RST = 8'h00;
    localparam logic [7:0] MAX_DUTY_RST = 8'hF0;
    localparam logic [7:0] START_TEMP_RST = 8'h28;
    localparam logic [7:0] DUTY_STEP_RST = 8'h02;

    localparam int CFG_INVERT_BIT = 4;
    localparam int CFG_MIN_DUTY_BIT = 3;
    localparam int CFG_SPIN_DIS_BIT = 2;
    localparam int FCFG_HYST_BIT = 7;
    localparam int FCFG_TSTEP_BIT = 6;
    localparam int FCFG_SEL1_LSB = 4;
    localparam int FCFG_SEL2_LSB = 2;
    localparam int OT_CH1_BIT = 7;
    localparam int OT_CH2_BIT = 6;

    localparam int FREQ_33HZ = 33;
    localparam int FREQ_35KHZ = 35_000;
    localparam int PWM_STEPS = 240;

    typedef enum logic [1:0] {
        FAN_RUN = 2'b00,
        FAN_SPIN = 2'b01
    } fan_state_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } reg_req_t;

    // clocks per pwm step; codes between the two ends double the frequency each time
    function automatic logic [12:0] pwm_div(input logic [2:0] code);
        int f;
        f = (code == 3'h7) ? FREQ_35KHZ : (FREQ_33HZ << code);
        pwm_div = 13'(CLK_HZ / (PWM_STEPS * f));
    endfunction

endpackage

// file: thermal_fan_pwm_control.sv
// temperature-driven two-fan pwm controller with over-temperature alert
//
// Contract
// R1 - convert both channels in turn, 120 ms each
// R2 - negative results clip to zero
// R3 - high byte whole degrees, low byte eighths
// R4 - over threshold sets flag, unmasked asserts alert
// R5 - masked channel sets flag, no alert
// R6 - status read clears flags and alert
// R7 - masking a channel drops its alert
// R8 - flag and alert reassert next conversion
// R9 - config bit 4 selects pwm polarity
// R10 - start from standstill: full on 2 s
// R11 - spin-up disabled: jump straight to nominal duty
// R12 - frequency register sets pwm frequency
// R13 - both select bits clear: manual mode
// R14 - manual duty clipped to 240, max ignored
// R15 - below start: zero or start duty
// R16 - duty = start + excess * step / tempstep
// R17 - recompute rising, hold until 5 C drop
// R18 - return below start minus hysteresis only
// R19 - auto duty clamped to maximum register
// R20 - fan config bit 6 selects temperature step
// R21 - start temperature belongs to the channel
// R22 - odd duty rounded down to even
// R23 - instantaneous duty ramps toward target at rate
// R24 - status bit 7 channel 1, bit 6 channel 2
// R25 - mask bit 7 channel 1, bit 6 channel 2
// R26 - duty 240 is full scale, 240 steps
`timescale 1ns/1ns
`default_nettype none

module thermal_fan_pwm_control #(
    parameter int CONV_CYCLES_P = fan_ctl_pkg::CONV_CYCLES,
    parameter int MS_CYCLES_P = fan_ctl_pkg::MS_CYCLES
) (
    input wire logic clock_in,
    input wire logic srst_in,
    input wire fan_ctl_pkg::reg_req_t reg_req_in,
    output logic [7:0] reg_rdata_out,
    input wire logic signed [11:0] temp_raw_1_in,
    input wire logic signed [11:0] temp_raw_2_in,
    output logic conv_chan_out,
    output logic overtemp_alert_n_out,
    output logic fan_drive_out_1,
    output logic fan_drive_out_2
);
    import fan_ctl_pkg::*;

    logic [22:0] conv_cnt_reg;
    logic chan_reg;
    logic [15:0] ms_cnt_reg;
    logic [12:0] pre_cnt_reg;
    logic [7:0] pwm_cnt_reg;
    logic [7:0] temp_hi_reg [2];
    logic [7:0] temp_lo_reg [2];
    logic [7:0] ot_limit_reg [2];
    logic [7:0] start_duty_reg [2];
    logic [7:0] max_duty_reg [2];
    logic [7:0] target_reg [2];
    logic [7:0] start_temp_reg [2];
    logic [7:0] cur_duty_reg [2];
    logic [7:0] cfg_reg;
    logic [7:0] fcfg_reg;
    logic [7:0] mask_reg;
    logic [7:0] status_reg;
    logic [7:0] offset_reg;
    logic [7:0] step_reg;
    logic [7:0] rate_reg;
    logic [2:0] freq_reg;
    logic [7:0] rdata_reg;
    logic [1:0] drive_reg;
    logic [7:0] rd_mux;

    wire conv_done = (conv_cnt_reg == 23'(CONV_CYCLES_P - 1));
    wire ms_tick = (ms_cnt_reg == 16'(MS_CYCLES_P - 1));
    wire pwm_tick = (pre_cnt_reg >= pwm_div(freq_reg) - 13'h0001);
    wire status_rd = reg_req_in.rd && (reg_req_in.addr == ADDR_OT_STATUS);
    wire signed [11:0] raw_sel = chan_reg ? temp_raw_2_in : temp_raw_1_in;
    wire signed [12:0] adj = 13'(raw_sel) + 13'({{2{offset_reg[7]}}, offset_reg, 3'h0});
    wire adj_neg = adj[12];
    wire adj_sat = !adj_neg && (adj[11] != 1'b0);
    wire [7:0] new_hi = adj_neg ? 8'h00 : (adj_sat ? 8'hFF : adj[10:3]);
    wire [7:0] new_lo = adj_neg ? 8'h00 : (adj_sat ? 8'hE0 : {adj[2:0], 5'h00});
    wire [1:0] over_limit = {temp_hi_reg[0] > ot_limit_reg[0], temp_hi_reg[1] > ot_limit_reg[1]};
    wire [1:0] mask_bits = {mask_reg[OT_CH1_BIT], mask_reg[OT_CH2_BIT]};
    wire [1:0] stat_bits = {status_reg[OT_CH1_BIT], status_reg[OT_CH2_BIT]};

    assign conv_chan_out = chan_reg;
    assign reg_rdata_out = rdata_reg;
    assign overtemp_alert_n_out = ~|(stat_bits & ~mask_bits);  // see R4 see R5 see R7
    assign fan_drive_out_1 = drive_reg[0];
    assign fan_drive_out_2 = drive_reg[1];

    // the converter keeps cycling forever; the unused channel is converted too
    always_ff @(posedge clock_in) begin
        if (srst_in || conv_done) begin
            conv_cnt_reg <= 23'h000000;
        end else begin
            conv_cnt_reg <= conv_cnt_reg + 23'h000001;  // see R1
        end
    end

    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            chan_reg <= 1'b0;
        end else if (conv_done) begin
            chan_reg <= ~chan_reg;  // see R1
        end
    end

    always_ff @(posedge clock_in) begin
        if (srst_in || ms_tick) begin
            ms_cnt_reg <= 16'h0000;
        end else begin
            ms_cnt_reg <= ms_cnt_reg + 16'h0001;
        end
    end

    // pwm period is 240 steps so a duty of 240 means always on
    always_ff @(posedge clock_in) begin
        if (srst_in || pwm_tick) begin
            pre_cnt_reg <= 13'h0000;  // see R12
        end else begin
            pre_cnt_reg <= pre_cnt_reg + 13'h0001;
        end
    end

    always_ff @(posedge clock_in) begin
        if (srst_in || (pwm_tick && pwm_cnt_reg == DUTY_FULL - 8'h01)) begin
            pwm_cnt_reg <= 8'h00;  // see R26
        end else if (pwm_tick) begin
            pwm_cnt_reg <= pwm_cnt_reg + 8'h01;
        end
    end

    // hardware set wins over the read clear so a fault in the clearing cycle survives
    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            status_reg <= ZERO_RST;  // see R24
        end else begin
            status_reg <= (status_rd ? 8'h00 : status_reg)  // see R6
                | ({7'h00, conv_done && !chan_reg && over_limit[1]} << OT_CH1_BIT)
                | ({7'h00, conv_done && chan_reg && over_limit[0]} << OT_CH2_BIT);  // see R8
        end
    end

    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            rdata_reg <= 8'h00;
        end else if (reg_req_in.rd) begin
            rdata_reg <= rd_mux;
        end
    end

    // single-instance registers written from the byte port
    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            cfg_reg <= CFG_RST;
            fcfg_reg <= ZERO_RST;
            mask_reg <= ZERO_RST;
            offset_reg <= ZERO_RST;
            step_reg <= DUTY_STEP_RST;
            rate_reg <= ZERO_RST;
            freq_reg <= 3'h0;
        end else if (reg_req_in.wr) begin
            case (reg_req_in.addr)
                ADDR_CFG: cfg_reg <= reg_req_in.wdata;
                ADDR_FAN_CFG: fcfg_reg <= reg_req_in.wdata;
                ADDR_OT_MASK: mask_reg <= reg_req_in.wdata;  // see R25
                ADDR_OFFSET: offset_reg <= reg_req_in.wdata;
                ADDR_DUTY_STEP: step_reg <= reg_req_in.wdata;
                ADDR_RATE: rate_reg <= reg_req_in.wdata;
                ADDR_FREQ: freq_reg <= reg_req_in.wdata[2:0];  // see R12
                default: ;
            endcase
        end
    end

    always_comb begin
        case (reg_req_in.addr)
            ADDR_TEMP1: rd_mux = temp_hi_reg[0];
            ADDR_TEMP2: rd_mux = temp_hi_reg[1];
            ADDR_TEMP1_LO: rd_mux = temp_lo_reg[0];
            ADDR_TEMP2_LO: rd_mux = temp_lo_reg[1];
            ADDR_CFG: rd_mux = cfg_reg;
            ADDR_OT_LIM1: rd_mux = ot_limit_reg[0];
            ADDR_OT_LIM2: rd_mux = ot_limit_reg[1];
            ADDR_OT_STATUS: rd_mux = status_reg;
            ADDR_OT_MASK: rd_mux = mask_reg;
            ADDR_START_DUTY1: rd_mux = start_duty_reg[0];
            ADDR_START_DUTY2: rd_mux = start_duty_reg[1];
            ADDR_MAX_DUTY1: rd_mux = max_duty_reg[0];
            ADDR_MAX_DUTY2: rd_mux = max_duty_reg[1];
            ADDR_TARGET1: rd_mux = target_reg[0];
            ADDR_TARGET2: rd_mux = target_reg[1];
            ADDR_START_TEMP1: rd_mux = start_temp_reg[0];
            ADDR_START_TEMP2: rd_mux = start_temp_reg[1];
            ADDR_DUTY_STEP: rd_mux = step_reg;
            ADDR_RATE: rd_mux = rate_reg;
            ADDR_FAN_CFG: rd_mux = fcfg_reg;
            ADDR_FREQ: rd_mux = {5'h00, freq_reg};
            ADDR_DUTY1: rd_mux = cur_duty_reg[0];
            ADDR_DUTY2: rd_mux = cur_duty_reg[1];
            ADDR_OFFSET: rd_mux = offset_reg;
            default: rd_mux = 8'h00;
        endcase
    end

    genvar i;
    generate
        for (i = 0; i < 2; i++) begin : g_ch
            // index i is the temperature channel for readings, limits and start temperatures, the fan for duty registers
            wire wr_hit = reg_req_in.wr;
            wire [7:0] a = reg_req_in.addr;

            always_ff @(posedge clock_in) begin
                if (srst_in) begin
                    temp_hi_reg[i] <= 8'h00;
                    temp_lo_reg[i] <= 8'h00;
                end else if (conv_done && (chan_reg == 1'(i))) begin
                    temp_hi_reg[i] <= new_hi;  // see R2 see R3
                    temp_lo_reg[i] <= new_lo;  // see R3
                end
            end

            always_ff @(posedge clock_in) begin
                if (srst_in) begin
                    ot_limit_reg[i] <= (i == 0) ? OT_LIM1_RST : OT_LIM2_RST;
                    start_duty_reg[i] <= ZERO_RST;
                    max_duty_reg[i] <= MAX_DUTY_RST;
                    target_reg[i] <= ZERO_RST;
                    start_temp_reg[i] <= START_TEMP_RST;
                end else if (wr_hit) begin
                    if (a == ((i == 0) ? ADDR_OT_LIM1 : ADDR_OT_LIM2)) begin
                        ot_limit_reg[i] <= reg_req_in.wdata;
                    end
                    if (a == ((i == 0) ? ADDR_START_DUTY1 : ADDR_START_DUTY2)) begin
                        start_duty_reg[i] <= reg_req_in.wdata;
                    end
                    if (a == ((i == 0) ? ADDR_MAX_DUTY1 : ADDR_MAX_DUTY2)) begin
                        max_duty_reg[i] <= reg_req_in.wdata;
                    end
                    if (a == ((i == 0) ? ADDR_TARGET1 : ADDR_TARGET2)) begin
                        target_reg[i] <= reg_req_in.wdata;
                    end
                    if (a == ((i == 0) ? ADDR_START_TEMP1 : ADDR_START_TEMP2)) begin
                        start_temp_reg[i] <= reg_req_in.wdata;
                    end
                end
            end
        end

        for (i = 0; i < 2; i++) begin : g_fan
            fan_state_t state_reg;
            logic [7:0] goal_reg;
            logic [7:0] peak_reg;
            logic active_reg;
            logic [7:0] rate_cnt_reg;
            logic [10:0] spin_cnt_reg;

            wire [1:0] sel = (i == 0) ? fcfg_reg[FCFG_SEL1_LSB +: 2] : fcfg_reg[FCFG_SEL2_LSB +: 2];
            wire auto_mode = (sel != 2'b00);  // see R13
            wire ch = (sel != 2'b01);
            wire [7:0] t = temp_hi_reg[ch];
            wire [7:0] start_temperature = start_temp_reg[ch];  // see R21
            wire update = conv_done && (chan_reg == ch);
            wire above = t > start_temperature;
            wire [7:0] hyst = fcfg_reg[FCFG_HYST_BIT] ? HYST_HI_C : HYST_LO_C;
            wire below_off = ({1'b0, t} + {1'b0, hyst}) < {1'b0, start_temperature};  // see R18
            wire peak_move = (t > peak_reg) || (({1'b0, t} + {1'b0, PEAK_DROP_C}) <= {1'b0, peak_reg});
            wire [15:0] scaled = 16'((t - start_temperature) * step_reg) >> fcfg_reg[FCFG_TSTEP_BIT];  // see R16 see R20
            wire [16:0] sum = 17'(start_duty_reg[i]) + 17'(scaled);
            wire [7:0] clamp_auto = (sum > 17'(max_duty_reg[i])) ? max_duty_reg[i] : sum[7:0];  // see R19
            wire [7:0] clamp_full = (clamp_auto > DUTY_FULL) ? DUTY_FULL : clamp_auto;
            wire [7:0] calc = {clamp_full[7:1], 1'b0};  // see R22
            wire [7:0] floor_duty = cfg_reg[CFG_MIN_DUTY_BIT] ? start_duty_reg[i] : 8'h00;  // see R15
            wire [7:0] man_clip = (target_reg[i] > DUTY_FULL) ? DUTY_FULL : target_reg[i];  // see R14
            wire rate_tick = ms_tick && (rate_cnt_reg == rate_reg);
            wire spin_done = ms_tick && (spin_cnt_reg == 11'(SPINUP_TIME_MS - 1));
            wire [8:0] up2 = {1'b0, cur_duty_reg[i]} + 9'h002;
            wire on_now = (state_reg == FAN_SPIN) || (pwm_cnt_reg < cur_duty_reg[i]);

            // in auto mode duty is only recomputed on a fresh conversion of the channel its select bits pick; manual mode follows the target every cycle
            always_ff @(posedge clock_in) begin
                if (srst_in) begin
                    goal_reg <= 8'h00;
                    peak_reg <= 8'h00;
                    active_reg <= 1'b0;
                end else if (!auto_mode) begin
                    goal_reg <= {man_clip[7:1], 1'b0};  // see R14 see R22
                    peak_reg <= 8'h00;
                    active_reg <= 1'b0;
                end else if (update) begin
                    if (above && (!active_reg || peak_move)) begin
                        goal_reg <= calc;  // see R17
                        peak_reg <= t;
                        active_reg <= 1'b1;
                    end else if (!above && (!active_reg || below_off)) begin
                        goal_reg <= {floor_duty[7:1], 1'b0};  // see R15 see R18
                        peak_reg <= 8'h00;
                        active_reg <= 1'b0;
                    end
                end
            end

            always_ff @(posedge clock_in) begin
                if (srst_in || rate_tick || state_reg == FAN_SPIN) begin
                    rate_cnt_reg <= 8'h00;
                end else if (ms_tick) begin
                    rate_cnt_reg <= rate_cnt_reg + 8'h01;
                end
            end

            always_ff @(posedge clock_in) begin
                if (srst_in || state_reg != FAN_SPIN) begin
                    spin_cnt_reg <= 11'h000;
                end else if (ms_tick) begin
                    spin_cnt_reg <= spin_cnt_reg + 11'h001;
                end
            end

            always_ff @(posedge clock_in) begin
                if (srst_in) begin
                    state_reg <= FAN_RUN;
                    cur_duty_reg[i] <= 8'h00;
                end else begin
                    case (state_reg)
                        FAN_RUN: begin
                            if (cur_duty_reg[i] == 8'h00 && goal_reg != 8'h00) begin
                                if (cfg_reg[CFG_SPIN_DIS_BIT]) begin
                                    cur_duty_reg[i] <= goal_reg;  // see R11
                                end else begin
                                    state_reg <= FAN_SPIN;  // see R10
                                end
                            end else if (rate_tick && goal_reg > cur_duty_reg[i]) begin
                                cur_duty_reg[i] <= (up2 > {1'b0, goal_reg}) ? goal_reg : up2[7:0];  // see R23
                            end else if (rate_tick && goal_reg < cur_duty_reg[i]) begin
                                cur_duty_reg[i] <= (cur_duty_reg[i] - goal_reg < 8'h02) ? goal_reg
                                    : cur_duty_reg[i] - 8'h02;  // see R23
                            end
                        end
                        FAN_SPIN: begin
                            if (spin_done) begin
                                cur_duty_reg[i] <= goal_reg;  // see R10
                                state_reg <= FAN_RUN;
                            end
                        end
                        default: state_reg <= FAN_RUN;
                    endcase
                end
            end

            // invert bit set means the drive is active high
            always_ff @(posedge clock_in) begin
                if (srst_in) begin
                    drive_reg[i] <= 1'b0;
                end else begin
                    drive_reg[i] <= cfg_reg[CFG_INVERT_BIT] ? on_now : ~on_now;  // see R9
                end
            end
        end
    endgenerate

endmodule

`default_nettype wire

// file: thermal_fan_pwm_control_properties.sv
// port-level assertions for the thermal fan controller
`timescale 1ns/1ns
`default_nettype none
module thermal_fan_pwm_control_properties #(
    parameter int CONV_CYCLES_P = 64,
    parameter int MS_CYCLES_P = 8
) (
    input wire logic clock_in,
    input wire logic srst_in,
    input wire fan_ctl_pkg::reg_req_t reg_req_in,
    input wire logic [7:0] reg_rdata_out,
    input wire logic signed [11:0] temp_raw_1_in,
    input wire logic signed [11:0] temp_raw_2_in,
    input wire logic conv_chan_out,
    input wire logic overtemp_alert_n_out,
    input wire logic fan_drive_out_1,
    input wire logic fan_drive_out_2
);
    import fan_ctl_pkg::*;
    // seeded with 1 on a change so the first slot after reset counts the same as later ones
    int cnt_reg;
    logic last_chan_reg;
    wire logic moved = conv_chan_out != last_chan_reg;
    wire logic rd_stat = reg_req_in.rd && reg_req_in.addr == ADDR_OT_STATUS;
    wire logic rd_duty = reg_req_in.rd && (reg_req_in.addr == ADDR_DUTY1 || reg_req_in.addr == ADDR_DUTY2);
    always_ff @(posedge clock_in) begin
        last_chan_reg <= srst_in ? 1'b0 : conv_chan_out;
        cnt_reg <= srst_in ? 0 : (moved ? 1 : cnt_reg + 1);
    end
    default clocking @(posedge clock_in);
    endclocking
    default disable iff (srst_in);
    chk_slot_length: assert property (moved |-> cnt_reg == CONV_CYCLES_P)
        else $error("channel slot has wrong length");
    chk_slot_bound: assert property (cnt_reg <= CONV_CYCLES_P)
        else $error("channel never switched");
    chk_reset_state: assert property ($fell(srst_in) |-> !fan_drive_out_1 && !fan_drive_out_2
        && overtemp_alert_n_out && reg_rdata_out == ZERO_RST)
        else $error("outputs wrong after reset");
    chk_mask_drop: assert property (reg_req_in.wr && reg_req_in.addr == ADDR_OT_MASK
        && reg_req_in.wdata[7:6] == 2'b11 |=> overtemp_alert_n_out)
        else $error("alert stayed low after masking");
    chk_read_clear: assert property (rd_stat && cnt_reg > 4 && cnt_reg < CONV_CYCLES_P - 4
        |=> overtemp_alert_n_out [*3])
        else $error("alert not released by status read");
    chk_alert_moment: assert property ($fell(overtemp_alert_n_out)
        |-> moved || cnt_reg <= 3 || $past(reg_req_in.wr))
        else $error("alert asserted away from a conversion");
    chk_status_bits: assert property (rd_stat |=> reg_rdata_out[5:0] == 6'h00)
        else $error("status has stray bits");
    chk_duty_even: assert property (rd_duty |=> !reg_rdata_out[0] && reg_rdata_out <= DUTY_FULL)
        else $error("duty odd or above full scale");
endmodule
bind thermal_fan_pwm_control thermal_fan_pwm_control_properties #(.CONV_CYCLES_P(CONV_CYCLES_P),
    .MS_CYCLES_P(MS_CYCLES_P)) u_chk (.clock_in(clock_in), .srst_in(srst_in), .reg_req_in(reg_req_in),
    .reg_rdata_out(reg_rdata_out), .temp_raw_1_in(temp_raw_1_in), .temp_raw_2_in(temp_raw_2_in),
    .conv_chan_out(conv_chan_out), .overtemp_alert_n_out(overtemp_alert_n_out),
    .fan_drive_out_1(fan_drive_out_1), .fan_drive_out_2(fan_drive_out_2));
`default_nettype wire

// file: fan_pwm_meter.sv
// fan with a pwm input: counts powered cycles in a window
`timescale 1ns/1ns
`default_nettype none
module fan_pwm_meter (
    input wire logic clock_in,
    input wire logic drive_in,
    input wire logic active_high_in,
    input wire logic clear_in,
    output logic [15:0] on_count_out,
    output logic [15:0] total_out
);
    // the fan runs while the line sits at its active level
    wire logic powered = drive_in == active_high_in;
    always_ff @(posedge clock_in) begin
        on_count_out <= clear_in ? 16'h0000 : on_count_out + 16'(powered);
        total_out <= clear_in ? 16'h0000 : total_out + 16'h0001;
    end
endmodule
`default_nettype wire

// file: thermal_fan_pwm_control_tb_top.sv
// self-checking bench for the thermal fan controller
`timescale 1ns/1ns
`default_nettype none
module thermal_fan_pwm_control_tb_top;
    import fan_ctl_pkg::*;
    logic clock_in = 1'b0;
    logic srst_in = 1'b1;
    reg_req_t req = '0;
    logic signed [11:0] raw1 = '0;
    logic signed [11:0] raw2 = '0;
    logic clr = 1'b0;
    logic act_hi = 1'b1;
    logic [7:0] rdata;
    logic chan, alert_n, drive1, drive2;
    logic [15:0] mon, mt;
    int n_mismatch = 0;
    int checks_done = 0;
    always #10 clock_in = ~clock_in;
    thermal_fan_pwm_control #(.CONV_CYCLES_P(64), .MS_CYCLES_P(8)) u_dut (.clock_in(clock_in),
        .srst_in(srst_in), .reg_req_in(req), .reg_rdata_out(rdata), .temp_raw_1_in(raw1),
        .temp_raw_2_in(raw2), .conv_chan_out(chan), .overtemp_alert_n_out(alert_n),
        .fan_drive_out_1(drive1), .fan_drive_out_2(drive2));
    fan_pwm_meter u_meter (.clock_in(clock_in), .drive_in(drive1), .active_high_in(act_hi),
        .clear_in(clr), .on_count_out(mon), .total_out(mt));
    task automatic finish_test();
        $display("mismatches %0d checks %0d", n_mismatch, checks_done);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clock_in);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock_in);
        req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clock_in);
        req.wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clock_in);
        req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clock_in);
        req.rd <= 1'b0;
        #1;
        chk8(rdata, exp);
    endtask
    task automatic wait_slots(input int n);
        logic c;
        repeat (n) begin
            c = chan;
            for (int i = 0; i < 200 && chan === c; i++) @(posedge clock_in);
        end
        tick(8);
    endtask
    // window of whole pwm periods so the powered count is exact whatever the phase
    task automatic measure(input logic [15:0] win, input logic [15:0] exp_on);
        @(posedge clock_in);
        clr <= 1'b1;
        @(posedge clock_in);
        clr <= 1'b0;
        for (int i = 0; i < 20000 && mt !== win; i++) begin
            @(posedge clock_in);
            #1;
        end
        chk16(mon, exp_on);
    endtask
    task automatic t_reset();
        rd(ADDR_CFG, CFG_RST);
        rd(ADDR_OT_STATUS, 8'h00);
        rd(ADDR_OT_MASK, 8'h00);
        rd(ADDR_FAN_CFG, 8'h00);
        rd(8'h1F, 8'h00);
        chk8({5'h00, alert_n, drive1, drive2}, 8'h04);
    endtask
    task automatic t_temp();
        wr(ADDR_OFFSET, 8'hFF);
        raw1 <= 12'sd211;
        raw2 <= -12'sd16;
        wait_slots(3);
        rd(ADDR_TEMP1, 8'h19);
        rd(ADDR_TEMP1_LO, 8'h60);
        rd(ADDR_TEMP2, 8'h00);
        rd(ADDR_TEMP2_LO, 8'h00);
        raw2 <= 12'sd12;
        wait_slots(3);
        rd(ADDR_TEMP2_LO, 8'h80);
    endtask
    task automatic t_alert();
        wr(ADDR_OT_LIM1, 8'h14);
        wait_slots(3);
        chk8({7'h00, alert_n}, 8'h00);
        rd(ADDR_OT_STATUS, 8'h80);
        chk8({7'h00, alert_n}, 8'h01);
        wait_slots(2);
        chk8({7'h00, alert_n}, 8'h00);
        wr(ADDR_OT_MASK, 8'hC0);
        #1;
        chk8({7'h00, alert_n}, 8'h01);
        wait_slots(2);
        rd(ADDR_OT_STATUS, 8'h80);
        chk8({7'h00, alert_n}, 8'h01);
        wr(ADDR_OT_LIM1, OT_LIM1_RST);
        wr(ADDR_OT_MASK, 8'h00);
        rd(ADDR_OT_STATUS, 8'h00);
    endtask
    // at the 35 kHz code one pwm step is 5 clocks, a period 1200
    task automatic t_manual();
        wr(ADDR_TARGET1, 8'hF8);
        // goal, spin state and the drive flop each take one edge before the pin goes high
        tick(2);
        measure(16'd15000, 16'd15000);
        tick(2000);
        rd(ADDR_DUTY1, DUTY_FULL);
        wr(ADDR_MAX_DUTY1, 8'h20);
        rd(ADDR_DUTY1, DUTY_FULL);
        wr(ADDR_FREQ, 8'h07);
        wr(ADDR_TARGET1, 8'h65);
        tick(1000);
        rd(ADDR_DUTY1, 8'h64);
        measure(16'd2400, 16'd1000);
        wr(ADDR_CFG, 8'h08);
        act_hi <= 1'b0;
        measure(16'd2400, 16'd1000);
        wr(ADDR_CFG, CFG_RST);
        act_hi <= 1'b1;
    endtask
    task automatic t_spin_off();
        wr(ADDR_TARGET1, 8'h00);
        tick(600);
        rd(ADDR_DUTY1, 8'h00);
        wr(ADDR_CFG, 8'h1C);
        wr(ADDR_TARGET1, 8'h40);
        tick(2);
        rd(ADDR_DUTY1, 8'h40);
        measure(16'd2400, 16'd640);
    endtask
    task automatic t_auto();
        wr(ADDR_START_TEMP1, 8'h14);
        wr(ADDR_START_DUTY1, 8'h10);
        wr(ADDR_FAN_CFG, 8'h10);
        wait_slots(3);
        tick(300);
        rd(ADDR_DUTY1, 8'h1A);
        wr(ADDR_MAX_DUTY1, 8'h12);
        // a rise past the peak forces a recompute; the goal uses the temperature stored one conversion earlier
        raw1 <= 12'sd300;
        wait_slots(4);
        tick(100);
        rd(ADDR_DUTY1, 8'h12);
    endtask
    initial begin
        #2000000;
        n_mismatch++;
        finish_test();
    end
    initial begin
        tick(20);
        srst_in <= 1'b0;
        t_reset();
        t_temp();
        t_alert();
        t_manual();
        t_spin_off();
        t_auto();
        finish_test();
    end
endmodule
`default_nettype wire
